// *** rtl/tmr_defs.svh ***
`ifndef TMR_DEFS_SVH
`define TMR_DEFS_SVH
// How it works
// - event mode counts valid input edges, interrupts after programmed count.
// - edges per interrupt equal data register value plus one.
// - event mode counter counts down.
// - start trigger in event mode loads counter from data register.
// - decrement per edge; at zero reload, interrupt, repeat forever.
// - data register writable anytime; new value used from next period.
// - power bit clear stops clocks, ignores writes; set powers up idle.
// - start trigger sets enabled status, waits for start edge; self-clears.
// - width mode start edge clears counter, counts up.
// - capture edge copies counter to data register, raises interrupt.
// - capture sets overflow flag if counter wrapped, else clears it.
// - after capture counter halts until next start edge.
// - counter value readable at any time.
// - stop trigger clears enabled, holds counter and overflow; self-clears.
// - clearing power bit initializes every circuit and register except the read data register (rdata).
// - input select zero takes the signal from the input pin.

// register offsets
`define REG_POWER 4'h0
`define REG_PRESC 4'h1
`define REG_MODE 4'h2
`define REG_TRIG 4'h3
`define REG_DATA 4'h4
`define REG_COUNT 4'h5
`define REG_STATUS 4'h6

// mode register fields
`define MODE_WIDTH 0
`define MODE_CLKSEL 1
`define MODE_START_LO 2
`define MODE_CAP_LO 4
`define MODE_INSEL 6
`define MODE_OUTEN 7
`define MODE_W 8

// trigger register fields
`define TRIG_START 0
`define TRIG_STOP 1

// status register fields
`define STAT_OVF 0
`define STAT_EN 1
`define STAT_WAIT 2

// reset values
`define PRESC_RST 8'h00
`define MODE_RST 8'h00
`define DATA_RST 16'h0000
`endif

// *** rtl/tmr_pkg.sv ***
package tmr_pkg;
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_WAIT,
        ST_RUN
    } phase_t;

    typedef struct packed {
        logic pwr;
        logic [7:0] presc;
        logic [7:0] mode;
        logic [15:0] data;
        logic [15:0] cnt;
        logic ovf;
        logic ovf_run;
        logic en;
        phase_t phase;
        logic in_prev;
        logic irq;
        logic [15:0] rdata;
        logic [15:0] div;
    } state_t;
endpackage

// *** rtl/timer_channel.sv ***
// Design decisions made here: the strobed register port and the register offsets.
`timescale 1ns/1ns
`include "tmr_defs.svh"
module timer_channel (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // register port
    input wire logic [3:0] addr,
    input wire logic [15:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [15:0] rdata,
    // signal inputs
    input wire logic timer_input_pin,
    input wire logic alt_input,
    // event output
    output logic channel_interrupt
);
    tmr_pkg::state_t q, d;

    function automatic logic tick_of(input logic [15:0] c,
                                     input logic [3:0] e);
        logic [15:0] m;
        m = 16'((17'h1 << e) - 17'h1);
        return (c & m) == m;
    endfunction

    // sel: bit0 rising, bit1 falling
    function automatic logic edge_hit(input logic [1:0] sel,
                                      input logic p, input logic c);
        return (sel[0] & ~p & c) | (sel[1] & p & ~c);
    endfunction

    logic op_tick;
    logic sig;
    logic start_edge;
    logic cap_edge;
    logic wr_ok;
    logic trig_start;
    logic trig_stop;

    always_comb begin
        wr_ok = wr & q.pwr;
        trig_start = wr_ok && addr == `REG_TRIG && wdata[`TRIG_START];
        trig_stop = wr_ok && addr == `REG_TRIG && wdata[`TRIG_STOP];
        // operating clock a or b from prescaler nibbles
        op_tick = q.mode[`MODE_CLKSEL] ? tick_of(q.div, q.presc[7:4])
                                       : tick_of(q.div, q.presc[3:0]);
        sig = q.mode[`MODE_INSEL] ? alt_input : timer_input_pin;
        // edges only on operating clock ticks, so one event each
        start_edge = op_tick && edge_hit(q.mode[`MODE_START_LO +: 2],
                                         q.in_prev, sig);
        cap_edge = op_tick && edge_hit(q.mode[`MODE_CAP_LO +: 2],
                                       q.in_prev, sig);
    end

    always_comb begin
        d = q;
        d.irq = 1'b0;
        d.rdata = q.rdata;
        if (q.pwr) begin
            d.div = q.div + 16'h1;
        end
        if (op_tick) begin
            d.in_prev = sig;
        end
        if (rd) begin
            case (addr)
                `REG_POWER: d.rdata = {15'h0, q.pwr};
                `REG_PRESC: d.rdata = {8'h0, q.presc};
                `REG_MODE: d.rdata = {8'h0, q.mode};
                `REG_DATA: d.rdata = q.data;
                `REG_COUNT: d.rdata = q.cnt;
                `REG_STATUS: d.rdata = {13'h0, q.phase == tmr_pkg::ST_WAIT,
                                        q.en, q.ovf};
                default: d.rdata = 16'h0000;
            endcase
        end
        if (wr_ok) begin
            case (addr)
                `REG_PRESC: d.presc = wdata[7:0];
                `REG_MODE: d.mode = wdata[7:0];
                `REG_DATA: d.data = wdata;
                default: d.mode = q.mode;
            endcase
        end
        if (q.en) begin
            if (!q.mode[`MODE_WIDTH]) begin
                // event counter, edges come from the start edge select
                if (start_edge) begin
                    if (q.cnt == 16'h0000) begin
                        d.cnt = q.data;
                        d.irq = 1'b1;
                    end else begin
                        d.cnt = q.cnt - 16'h1;
                    end
                end
            end else begin
                case (q.phase)
                    tmr_pkg::ST_WAIT: begin
                        if (start_edge) begin
                            d.cnt = 16'h0000;
                            d.ovf_run = 1'b0;
                            d.phase = tmr_pkg::ST_RUN;
                        end
                    end
                    tmr_pkg::ST_RUN: begin
                        if (cap_edge) begin
                            // capture beats a same-cycle software write
                            d.data = q.cnt;
                            d.irq = 1'b1;
                            d.ovf = q.ovf_run;
                            d.phase = tmr_pkg::ST_WAIT;
                        end else if (op_tick) begin
                            d.cnt = q.cnt + 16'h1;
                            if (q.cnt == 16'hFFFF) begin
                                d.ovf_run = 1'b1;
                            end
                        end
                    end
                    default: d.phase = tmr_pkg::ST_WAIT;
                endcase
            end
        end
        if (trig_start) begin
            d.en = 1'b1;
            d.phase = tmr_pkg::ST_WAIT;
            if (!q.mode[`MODE_WIDTH]) begin
                d.cnt = q.data;
            end
        end else if (trig_stop) begin
            // counter and overflow left as they are, even on an edge
            d.en = 1'b0;
            d.phase = tmr_pkg::ST_IDLE;
            d.cnt = q.cnt;
            d.ovf = q.ovf;
        end
        if (wr && addr == `REG_POWER) begin
            d.pwr = wdata[0];
        end
        if (!q.pwr) begin
            // unit except rdata held in its reset state while unpowered
            d.presc = `PRESC_RST;
            d.mode = `MODE_RST;
            d.data = `DATA_RST;
            d.cnt = 16'h0000;
            d.ovf = 1'b0;
            d.ovf_run = 1'b0;
            d.en = 1'b0;
            d.phase = tmr_pkg::ST_IDLE;
            d.in_prev = 1'b0;
            d.irq = 1'b0;
            d.div = 16'h0000;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign rdata = q.rdata;
    assign channel_interrupt = q.irq;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    // event counter mode
    ev_reload_a: assert property (
        q.en && !q.mode[`MODE_WIDTH] && start_edge && q.cnt == 16'h0000
        && !trig_start && !trig_stop && q.pwr |=>
        channel_interrupt && q.cnt == $past(q.data))
        else $error("event reload or interrupt missing");

    ev_dec_a: assert property (
        q.en && !q.mode[`MODE_WIDTH] && start_edge && q.cnt != 16'h0000
        && !trig_start && !trig_stop && q.pwr |=>
        !channel_interrupt && q.cnt == $past(q.cnt) - 16'h1)
        else $error("event counter did not decrement");

    start_load_a: assert property (
        trig_start && !q.mode[`MODE_WIDTH] |=>
        q.en && q.cnt == $past(q.data))
        else $error("start did not load counter");

    ev_irq_only_a: assert property (
        q.pwr && !q.mode[`MODE_WIDTH]
        && !(q.en && start_edge && q.cnt == 16'h0000) |=>
        !channel_interrupt)
        else $error("event interrupt without reload");

    edge_none_a: assert property (
        q.en && !q.mode[`MODE_WIDTH] && !trig_start && q.pwr
        && q.mode[`MODE_START_LO +: 2] == 2'b00 |=>
        $stable(q.cnt))
        else $error("count moved with no edge selected");

    // start and stop triggers
    start_wait_a: assert property (
        trig_start && q.mode[`MODE_WIDTH] |=>
        q.en && q.phase == tmr_pkg::ST_WAIT)
        else $error("start did not arm the wait state");

    stop_hold_a: assert property (
        trig_stop && !trig_start && q.pwr |=>
        !q.en && $stable(q.cnt) && $stable(q.ovf))
        else $error("stop did not hold state");

    idle_hold_a: assert property (
        !q.en && q.pwr && !trig_start |=>
        $stable(q.cnt) && !channel_interrupt)
        else $error("stopped channel moved");

    start_ovf_a: assert property (
        trig_start && !q.en |=> $stable(q.ovf))
        else $error("start changed the overflow flag");

    // width measurement mode
    meas_start_a: assert property (
        q.en && q.mode[`MODE_WIDTH] && q.phase == tmr_pkg::ST_WAIT
        && start_edge && !trig_start && !trig_stop && q.pwr |=>
        q.cnt == 16'h0000 && q.phase == tmr_pkg::ST_RUN)
        else $error("measurement start wrong");

    meas_up_a: assert property (
        q.en && q.mode[`MODE_WIDTH] && q.phase == tmr_pkg::ST_RUN
        && op_tick && !cap_edge && !trig_start && !trig_stop && q.pwr |=>
        q.cnt == $past(q.cnt) + 16'h1)
        else $error("measurement did not count up");

    run_ignore_a: assert property (
        q.en && q.mode[`MODE_WIDTH] && q.phase == tmr_pkg::ST_RUN
        && start_edge && !cap_edge && !trig_start && !trig_stop
        && q.pwr |=>
        q.phase == tmr_pkg::ST_RUN)
        else $error("start edge disturbed a running measurement");

    cap_data_a: assert property (
        q.en && q.mode[`MODE_WIDTH] && q.phase == tmr_pkg::ST_RUN
        && cap_edge && !trig_start && !trig_stop && q.pwr |=>
        channel_interrupt && q.data == $past(q.cnt)
        && q.ovf == $past(q.ovf_run))
        else $error("capture wrong");

    irq_width_a: assert property (
        q.pwr && q.mode[`MODE_WIDTH]
        && !(q.en && q.phase == tmr_pkg::ST_RUN && cap_edge) |=>
        !channel_interrupt)
        else $error("width interrupt without capture");

    ovf_set_a: assert property (
        q.en && q.mode[`MODE_WIDTH] && q.phase == tmr_pkg::ST_RUN
        && op_tick && !cap_edge && q.cnt == 16'hFFFF
        && !trig_start && !trig_stop && q.pwr |=>
        q.ovf_run && q.cnt == 16'h0000)
        else $error("wrap did not note overflow");

    cap_halt_a: assert property (
        q.en && q.mode[`MODE_WIDTH] && q.phase == tmr_pkg::ST_WAIT
        && !start_edge && !trig_start && !trig_stop && q.pwr |=>
        $stable(q.cnt))
        else $error("counter moved while waiting");

    wait_ignore_a: assert property (
        q.en && q.mode[`MODE_WIDTH] && q.phase == tmr_pkg::ST_WAIT
        && cap_edge && !start_edge && !trig_start && !trig_stop
        && q.pwr |=>
        !channel_interrupt)
        else $error("capture taken while waiting");

    // input selection and edge detection
    sel_pin_a: assert property (
        !q.mode[`MODE_INSEL] |-> sig == timer_input_pin)
        else $error("pin not selected");

    both_edge_a: assert property (
        q.pwr && op_tick && q.mode[`MODE_START_LO +: 2] == 2'b11
        && q.in_prev != sig |-> start_edge)
        else $error("both-edge select missed an edge");

    edge_once_a: assert property (
        q.pwr && op_tick |=> q.in_prev == $past(sig))
        else $error("input sample not taken on tick");

    no_tick_a: assert property (
        q.pwr && !op_tick && !trig_start |=>
        $stable(q.cnt) && !channel_interrupt)
        else $error("counter moved between ticks");

    // power gating and register port
    pwr_off_a: assert property (
        !q.pwr && !(wr && addr == `REG_POWER) |=>
        !q.en && q.data == `DATA_RST && q.mode == `MODE_RST)
        else $error("power off did not clear");

    wr_off_a: assert property (
        !q.pwr && wr && addr == `REG_DATA |=> q.data == `DATA_RST)
        else $error("write taken while unpowered");

    power_up_a: assert property (
        !q.pwr && wr && addr == `REG_POWER && wdata[0] |=> q.pwr && !q.en)
        else $error("power up did not leave channel stopped");

    div_stop_a: assert property (
        !q.pwr |=> q.div == 16'h0000)
        else $error("prescaler ran while unpowered");

    div_run_a: assert property (
        q.pwr |=> q.div == $past(q.div) + 16'h1)
        else $error("prescaler stalled while powered");

    data_write_a: assert property (
        wr_ok && addr == `REG_DATA
        && !(q.en && q.mode[`MODE_WIDTH] && q.phase == tmr_pkg::ST_RUN
        && cap_edge) |=> q.data == $past(wdata))
        else $error("data write lost");

    count_read_a: assert property (
        rd && addr == `REG_COUNT |=> rdata == $past(q.cnt))
        else $error("count readback wrong");

    rdata_hold_a: assert property (
        !rd |=> $stable(rdata))
        else $error("read data changed without a read");

    status_read_a: assert property (
        rd && addr == `REG_STATUS |=> rdata[1] == $past(q.en))
        else $error("enabled status readback wrong");

    trig_read_a: assert property (
        rd && addr == `REG_TRIG |=> rdata == 16'h0000)
        else $error("trigger bits did not read as zero");

    irq_pulse_a: assert property (
        channel_interrupt |=> !channel_interrupt)
        else $error("interrupt longer than one cycle");

    // main scenarios
    ev_irq_c: cover property (
        !q.mode[`MODE_WIDTH] && channel_interrupt);
    cap_c: cover property (
        q.mode[`MODE_WIDTH] && channel_interrupt && q.ovf);
    stop_c: cover property (q.en ##1 !q.en && q.pwr);
    meas_start_c: cover property (
        q.phase == tmr_pkg::ST_WAIT ##1 q.phase == tmr_pkg::ST_RUN);
    pwr_off_c: cover property (q.pwr ##1 !q.pwr);
endmodule

// *** bench/pulse_source.sv ***
`timescale 1ns/1ns
module pulse_source (
    // clock
    input wire logic clk_sys,
    // driven pin
    output logic pin
);
    initial pin = 1'b0;

    // one high pulse of hi cycles, then low for lo cycles
    task automatic pulse(input int hi, input int lo);
        @(posedge clk_sys);
        pin <= 1'b1;
        repeat (hi) @(posedge clk_sys);
        pin <= 1'b0;
        repeat (lo) @(posedge clk_sys);
    endtask
endmodule

// *** bench/test_timer_channel.sv ***
`timescale 1ns/1ns
`include "tmr_defs.svh"
module test_timer_channel;
    logic clk_sys = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [15:0] wdata = 16'h0000, rdata, v, w;
    logic pin, channel_interrupt;
    int fail_count = 0, checks = 0, irq_n = 0, base;

    timer_channel i_dut (.clk_sys(clk_sys), .rst(rst), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .timer_input_pin(pin), .alt_input(1'b0),
        .channel_interrupt(channel_interrupt));
    pulse_source i_src (.clk_sys(clk_sys), .pin(pin));

    initial forever #5 clk_sys = ~clk_sys;
    always @(posedge clk_sys) if (channel_interrupt === 1'b1) irq_n++;

    task automatic chk(string name, logic [15:0] seen, logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wr_reg(logic [3:0] a, logic [15:0] d);
        @(posedge clk_sys);
        wr <= 1'b1; addr <= a; wdata <= d;
        @(posedge clk_sys);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(logic [3:0] a, output logic [15:0] d);
        @(posedge clk_sys);
        rd <= 1'b1; addr <= a;
        @(posedge clk_sys);
        rd <= 1'b0;
        #1 d = rdata;
    endtask
    task automatic test_done;
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic power_gate;
        wr_reg(`REG_DATA, 16'h0033);
        rd_reg(`REG_DATA, v); chk("data_off", v, 16'h0000);
        wr_reg(`REG_POWER, 16'h0001);
        wr_reg(`REG_PRESC, 16'h0000);
    endtask
    task automatic event_count;
        wr_reg(`REG_MODE, 16'h0004);
        wr_reg(`REG_DATA, 16'h0002);
        wr_reg(`REG_TRIG, 16'h0001);
        rd_reg(`REG_COUNT, v); chk("load", v, 16'h0002);
        repeat (2) i_src.pulse(2, 3);
        rd_reg(`REG_COUNT, v); chk("down", v, 16'h0000);
        chk("irq_early", 16'(irq_n), 16'h0000);
        wr_reg(`REG_DATA, 16'h0001);
        i_src.pulse(2, 3);
        chk("irq_one", 16'(irq_n), 16'h0001);
        rd_reg(`REG_COUNT, v); chk("reload", v, 16'h0001);
        repeat (2) i_src.pulse(2, 3);
        chk("irq_two", 16'(irq_n), 16'h0002);
        wr_reg(`REG_TRIG, 16'h0002);
    endtask
    task automatic edge_select;
        base = irq_n;
        wr_reg(`REG_MODE, 16'h004C);
        wr_reg(`REG_DATA, 16'h0001);
        wr_reg(`REG_TRIG, 16'h0001);
        i_src.pulse(2, 3);
        chk("alt_in", 16'(irq_n - base), 16'h0000);
        wr_reg(`REG_TRIG, 16'h0002);
        wr_reg(`REG_MODE, 16'h000C);
        wr_reg(`REG_TRIG, 16'h0001);
        i_src.pulse(2, 3);
        chk("both", 16'(irq_n - base), 16'h0001);
        wr_reg(`REG_TRIG, 16'h0002);
    endtask
    task automatic width_measure;
        int n;
        base = irq_n;
        wr_reg(`REG_MODE, 16'h0025);
        wr_reg(`REG_TRIG, 16'h0001);
        rd_reg(`REG_STATUS, v); chk("wait", v, 16'h0006);
        rd_reg(`REG_TRIG, v); chk("trig_clr", v, 16'h0000);
        i_src.pulse(10, 0);
        n = 0;
        while (irq_n == base && n < 50) begin
            @(posedge clk_sys);
            n++;
        end
        if (n == 50) begin
            fail_count++;
            test_done;
        end
        rd_reg(`REG_DATA, v); chk("capture", v, 16'h0009);
        rd_reg(`REG_STATUS, v); chk("no_ovf", v, 16'h0006);
        rd_reg(`REG_COUNT, v);
        repeat (5) @(posedge clk_sys);
        rd_reg(`REG_COUNT, w); chk("halt", w, v);
        wr_reg(`REG_TRIG, 16'h0002);
        rd_reg(`REG_STATUS, v); chk("stop", v & 16'h0002, 16'h0000);
        rd_reg(`REG_COUNT, v); chk("held", v, w);
    endtask
    task automatic power_off;
        wr_reg(`REG_POWER, 16'h0000);
        rd_reg(`REG_DATA, v); chk("data_rst", v, 16'h0000);
        rd_reg(`REG_MODE, v); chk("mode_rst", v, 16'h0000);
    endtask

    initial begin
        repeat (20) @(posedge clk_sys);
        rst <= 1'b0;
        power_gate();
        event_count();
        edge_select();
        width_measure();
        power_off();
        test_done();
    end
    initial begin
        repeat (20000) @(posedge clk_sys);
        fail_count++;
        test_done();
    end
endmodule
